// >>> rtl/ring_edge_sense.sv
/*
 Selects one of two free-running ring oscillator outputs and brings it into
 the core clock domain, reporting its rising and falling edges as pulses.
 Assumes the raw oscillator inputs are fully asynchronous to i_clk.
*/
`timescale 1ns/10ps
module ring_edge_sense (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_fast_raw,
	input wire logic i_slow_raw,
	input wire logic i_sel_slow,
	output logic o_rise,
	output logic o_fall
);
	localparam int RING_COUNT = 2;
	logic [RING_COUNT-1:0] ring_raw;
	logic [RING_COUNT-1:0] sync_meta;
	logic [RING_COUNT-1:0] sync_level;
	logic ring_out;
	logic ring_prev;

	assign ring_raw = {i_slow_raw, i_fast_raw};

	// two-flop synchroniser per oscillator
	// Both rings are synchronised before the select, so no gate sees a raw pin
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync_meta <= '0;
			sync_level <= '0;
			ring_prev <= 1'b0;
		end else begin
			sync_meta <= ring_raw;
			sync_level <= sync_meta;
			ring_prev <= ring_out;
		end
	end

	// oscillator output select
	// Changing the select can fake one edge when the two levels differ
	assign ring_out = i_sel_slow ? sync_level[1] : sync_level[0];

	// Edges faster than half the core clock alias; good enough for entropy
	assign o_rise = ring_out & ~ring_prev;
	assign o_fall = ~ring_out & ring_prev;
endmodule // ring_edge_sense

// >>> rtl/ring_lfsr_rng.sv
/*
 Random number generator: control register, ring-oscillator driven 8-bit
 shift register and a 16-bit shift register stepped by core reads of its low byte.
 Assumes the ring oscillators are hard macros outside, with a stop input each,
 and a core bus with one-cycle read and write strobes.
*/
`timescale 1ns/10ps
module ring_lfsr_rng (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [rng_pkg::ADDR_W-1:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [rng_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_fast_ring,
	input wire logic i_slow_ring,
	output logic [rng_pkg::DATA_W-1:0] o_rdata,
	output logic o_fast_ring_stop,
	output logic o_slow_ring_stop
);
	logic rst_meta;
	logic rst_b;
	logic [rng_pkg::DATA_W-1:0] rng_control;
	logic [rng_pkg::DATA_W-1:0] byte_feedback_shift;
	logic [rng_pkg::WORD_W-1:0] word_feedback_shift;
	logic [rng_pkg::WORD_W-1:0] next_word;
	logic [rng_pkg::DATA_W-1:0] poly_coeff_term;
	logic [rng_pkg::DATA_W-1:0] next_byte;
	logic [rng_pkg::DATA_W-1:0] read_mux;
	logic ring_rise;
	logic ring_fall;
	logic ring_clocked;
	logic sel_control;
	logic sel_byte;
	logic sel_high;
	logic sel_low;
	logic wr_control;
	logic wr_byte;
	logic wr_high;
	logic wr_low;
	logic rd_byte;
	logic rd_low;
	logic [rng_pkg::DATA_W-1:0] next_control;

	// Reset is taken at once but let go only on a clock edge
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_meta <= 1'b0;
			rst_b <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_b <= rst_meta;
		end
	end

	assign sel_control = (i_addr == rng_pkg::ADDR_CONTROL);
	assign sel_byte = (i_addr == rng_pkg::ADDR_BYTE_SHIFT);
	assign sel_high = (i_addr == rng_pkg::ADDR_WORD_HIGH);
	assign sel_low = (i_addr == rng_pkg::ADDR_WORD_LOW);

	// Access strobes per register; unmapped addresses decode to none
	assign wr_control = i_wr & sel_control;
	assign wr_byte = i_wr & sel_byte;
	assign wr_high = i_wr & sel_high;
	assign wr_low = i_wr & sel_low;
	assign rd_byte = i_rd & sel_byte;
	assign rd_low = i_rd & sel_low;

	assign ring_clocked = rng_control[rng_pkg::CTL_RING_CLOCK];

	ring_edge_sense u_edge (
		.i_clk(i_clk),
		.i_rst_b(rst_b),
		.i_fast_raw(i_fast_ring),
		.i_slow_raw(i_slow_ring),
		.i_sel_slow(rng_control[rng_pkg::CTL_RING_SLOW]),
		.o_rise(ring_rise),
		.o_fall(ring_fall)
	);

	// A flag written as one keeps, as zero clears
	always_comb begin
		next_control = rng_control;
		if (wr_control) begin
			next_control = (i_wdata & rng_pkg::CTL_WRITE_MASK)
				| (rng_control & i_wdata & ~rng_pkg::CTL_WRITE_MASK);
		end
		if (ring_clocked && ring_fall) begin
			next_control[rng_pkg::CTL_FALL_SEEN] = 1'b1;
		end
		if (ring_clocked && ring_rise) begin
			next_control[rng_pkg::CTL_RISE_SEEN] = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			rng_control <= rng_pkg::CONTROL_RESET;
		end else begin
			rng_control <= next_control;
		end
	end

	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			o_fast_ring_stop <= 1'b0;
		end else begin
			o_fast_ring_stop <= rng_control[rng_pkg::CTL_FAST_OFF];
		end
	end

	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			o_slow_ring_stop <= 1'b0;
		end else begin
			o_slow_ring_stop <= rng_control[rng_pkg::CTL_SLOW_OFF];
		end
	end

	assign next_byte = {byte_feedback_shift[rng_pkg::DATA_W-2:0],
		^(byte_feedback_shift & rng_pkg::BYTE_TAPS)};

	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			byte_feedback_shift <= rng_pkg::BYTE_SHIFT_RESET;
		end else if (ring_clocked) begin
			if (ring_rise) begin
				byte_feedback_shift <= next_byte;
			end
		end else if (wr_byte) begin
			byte_feedback_shift <= i_wdata;
		end else if (rd_byte) begin
			byte_feedback_shift <= next_byte;
		end
	end

	assign poly_coeff_term = byte_feedback_shift & {rng_pkg::DATA_W{rng_control[rng_pkg::CTL_POLY_ON]}};

	// polynomial toggles
	// Only four bits differ from a rotate; masked toggles leave a plain rotate
	always_comb begin
		next_word = {word_feedback_shift[0], word_feedback_shift[rng_pkg::WORD_W-1:1]};
		next_word[rng_pkg::WORD_FEED_BIT] =
			(poly_coeff_term[rng_pkg::COEF_A] & word_feedback_shift[rng_pkg::WORD_TAP_A])
			^ (poly_coeff_term[rng_pkg::COEF_B] & word_feedback_shift[rng_pkg::WORD_TAP_B])
			^ word_feedback_shift[0];
		next_word[rng_pkg::WORD_TOG_HI] = poly_coeff_term[rng_pkg::COEF_HI]
			^ word_feedback_shift[rng_pkg::WORD_TOG_HI+1];
		next_word[rng_pkg::WORD_TOG_MID] = poly_coeff_term[rng_pkg::COEF_MID]
			^ word_feedback_shift[rng_pkg::WORD_TOG_MID+1];
		next_word[rng_pkg::WORD_TOG_LO] = poly_coeff_term[rng_pkg::COEF_LO]
			^ word_feedback_shift[rng_pkg::WORD_TOG_LO+1];
	end

	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			word_feedback_shift <= rng_pkg::WORD_SHIFT_RESET;
		end else if (wr_high) begin
			word_feedback_shift[rng_pkg::WORD_W-1:rng_pkg::DATA_W] <= i_wdata;
		end else if (wr_low) begin
			// A write beats the step of a read in the same cycle
			word_feedback_shift[rng_pkg::DATA_W-1:0] <= i_wdata;
		end else if (rd_low) begin
			word_feedback_shift <= next_word;
		end
	end

	always_comb begin
		read_mux = 8'h00;
		if (sel_control) begin
			read_mux = rng_control & rng_pkg::CTL_READ_MASK;
		end else if (sel_byte) begin
			read_mux = byte_feedback_shift;
		end else if (sel_high) begin
			read_mux = word_feedback_shift[rng_pkg::WORD_W-1:rng_pkg::DATA_W];
		end else if (sel_low) begin
			read_mux = word_feedback_shift[rng_pkg::DATA_W-1:0];
		end
	end

	// Read data holds until the next read; value is taken before any step
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= read_mux;
		end
	end
endmodule // ring_lfsr_rng

// >>> rtl/rng_pkg.sv
/*
 Constants for the ring oscillator random number generator: register
 addresses, control bit positions, reset values and shift register taps.
 Assumes a byte-wide core bus with a 22-bit address.
*/
package rng_pkg;
	localparam int ADDR_W = 22;
	localparam int DATA_W = 8;
	localparam int WORD_W = 16;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = 22'h3f0108;
	localparam logic [ADDR_W-1:0] ADDR_BYTE_SHIFT = 22'h3f0109;
	localparam logic [ADDR_W-1:0] ADDR_WORD_HIGH = 22'h3f010a;
	localparam logic [ADDR_W-1:0] ADDR_WORD_LOW = 22'h3f010b;
	localparam int CTL_FAST_OFF = 6;
	localparam int CTL_SLOW_OFF = 5;
	localparam int CTL_FALL_SEEN = 4;
	localparam int CTL_RISE_SEEN = 3;
	localparam int CTL_POLY_ON = 2;
	localparam int CTL_RING_SLOW = 1;
	localparam int CTL_RING_CLOCK = 0;
	// Bits software may write directly; the two seen flags are write-zero-to-clear
	localparam logic [DATA_W-1:0] CTL_WRITE_MASK = 8'h67;
	localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h00;
	localparam logic [DATA_W-1:0] BYTE_SHIFT_RESET = 8'h01;
	localparam logic [WORD_W-1:0] WORD_SHIFT_RESET = 16'h0001;
	// Taps for x^8 + x^6 + x^5 + x^4 + 1, a maximal-length polynomial
	localparam logic [DATA_W-1:0] BYTE_TAPS = 8'hb8;
	// Control bit 7 is unused and always reads zero
	localparam logic [DATA_W-1:0] CTL_READ_MASK = 8'h7f;
	// Word step: bit 15 takes the feedback, three bits take toggles
	localparam int WORD_FEED_BIT = 15;
	localparam int WORD_TAP_A = 2;
	localparam int WORD_TAP_B = 3;
	localparam int WORD_TOG_HI = 13;
	localparam int WORD_TOG_MID = 12;
	localparam int WORD_TOG_LO = 6;
	// Byte register bits that act as polynomial coefficients
	localparam int COEF_A = 0;
	localparam int COEF_B = 1;
	localparam int COEF_HI = 4;
	localparam int COEF_MID = 5;
	localparam int COEF_LO = 7;
endpackage

// >>> tb/ring_lfsr_rng_bench.sv
/* Directed bench: register accesses and ring edges.
 Assumes rng_pkg and rng_properties are compiled first. */
`timescale 1ns/10ps
module ring_lfsr_rng_bench;
	localparam logic [21:0] CT = rng_pkg::ADDR_CONTROL;
	localparam logic [21:0] BY = rng_pkg::ADDR_BYTE_SHIFT;
	localparam logic [21:0] HI = rng_pkg::ADDR_WORD_HIGH;
	localparam logic [21:0] LO = rng_pkg::ADDR_WORD_LOW;
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic [21:0] i_addr = 22'h000000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] i_wdata = 8'h00;
	logic i_fast_ring = 1'b0;
	logic i_slow_ring = 1'b0;
	logic [7:0] o_rdata;
	logic o_fast_ring_stop;
	logic o_slow_ring_stop;
	int fails = 0;
	int cmp_count = 0;
	ring_lfsr_rng dut (.i_clk, .i_rst_b, .i_addr, .i_wr, .i_rd, .i_wdata, .i_fast_ring,
		.i_slow_ring, .o_rdata, .o_fast_ring_stop, .o_slow_ring_stop);
	initial begin
		forever #5 i_clk = ~i_clk;
	end
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [21:0] a, input logic [7:0] d);
		@(negedge i_clk);
		i_addr = a;
		i_wdata = d;
		i_wr = 1'b1;
		@(negedge i_clk);
		i_wr = 1'b0;
	endtask
	// Read data holds until the next read, so sampling a cycle late is safe
	task automatic rd(input logic [21:0] a, input logic [7:0] e, input string n);
		i_addr = a;
		i_rd = 1'b1;
		@(negedge i_clk);
		i_rd = 1'b0;
		@(negedge i_clk);
		chk(n, e, o_rdata);
	endtask
	// Slow edges only: the synchroniser needs a few cycles to see each one
	task automatic ring(input bit slow, input logic v);
		if (slow) begin
			i_slow_ring = v;
		end else begin
			i_fast_ring = v;
		end
		repeat (6) @(negedge i_clk);
	endtask
	initial begin
		#20us;
		fails++;
		stop_test();
	end
	initial begin
		repeat (2) @(negedge i_clk);
		i_rst_b = 1'b1;
		repeat (3) @(negedge i_clk);
		rd(CT, 8'h00, "ctl");
		rd(BY, 8'h01, "byte");
		rd(BY, 8'h02, "byte step");
		rd(LO, 8'h01, "low");
		rd(HI, 8'h80, "rotate");
		rd(LO, 8'h00, "low");
		rd(22'h3f010c, 8'h00, "unmapped");
		$display("reset test done");
		wr(CT, 8'h60);
		rd(CT, 8'h60, "ctl");
		chk("stops", 8'h03, {6'h00, o_fast_ring_stop, o_slow_ring_stop});
		wr(CT, 8'h07);
		wr(BY, 8'haa);
		rd(BY, 8'h04, "byte locked");
		chk("stops off", 8'h00, {6'h00, o_fast_ring_stop, o_slow_ring_stop});
		ring(1'b0, 1'b1);
		rd(BY, 8'h04, "unselected");
		ring(1'b1, 1'b1);
		rd(BY, 8'h08, "byte ring");
		rd(CT, 8'h0f, "rise flag");
		ring(1'b1, 1'b0);
		rd(CT, 8'h1f, "fall flag");
		$display("ring test done");
		wr(CT, 8'h04);
		rd(CT, 8'h04, "flags cleared");
		wr(BY, 8'hff);
		wr(HI, 8'h00);
		rd(HI, 8'h00, "high");
		wr(LO, 8'h01);
		rd(LO, 8'h01, "low");
		rd(BY, 8'hff, "byte load");
		rd(HI, 8'hb0, "poly high");
		rd(LO, 8'h40, "poly low");
		wr(CT, 8'h00);
		rd(LO, 8'h60, "masked low");
		rd(HI, 8'h34, "masked high");
		$display("poly test done");
		stop_test();
	end
endmodule // ring_lfsr_rng_bench
bind ring_lfsr_rng rng_properties u_props (.i_clk, .i_rst_b, .i_addr, .i_wr, .i_rd, .i_wdata,
	.o_rdata, .o_fast_ring_stop, .o_slow_ring_stop);

// >>> tb/rng_properties.sv
/* Assertions on the generator's register port.
 Assumes a bind to ring_lfsr_rng and one-cycle strobes. */
`timescale 1ns/10ps
module rng_properties (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [rng_pkg::ADDR_W-1:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [rng_pkg::DATA_W-1:0] i_wdata,
	input wire logic [rng_pkg::DATA_W-1:0] o_rdata,
	input wire logic o_fast_ring_stop,
	input wire logic o_slow_ring_stop
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	sequence s_acc(logic s, logic [21:0] a);
		s && i_addr == a;
	endsequence
	property p_unmap;
		i_rd && (i_addr < rng_pkg::ADDR_CONTROL || i_addr > rng_pkg::ADDR_WORD_LOW)
			|=> o_rdata == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_hold;
		!i_rd |=> $stable(o_rdata);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_fast;
		s_acc(i_wr, rng_pkg::ADDR_CONTROL) |-> ##2 o_fast_ring_stop == $past(i_wdata[6], 2);
	endproperty
	a_fast: assert property (p_fast) else $error("fast stop wrong");
	property p_slow;
		s_acc(i_wr, rng_pkg::ADDR_CONTROL) |-> ##2 o_slow_ring_stop == $past(i_wdata[5], 2);
	endproperty
	a_slow: assert property (p_slow) else $error("slow stop wrong");
	property p_fstay;
		$changed(o_fast_ring_stop) |-> $past(i_wr && i_addr == rng_pkg::ADDR_CONTROL, 2);
	endproperty
	a_fstay: assert property (p_fstay) else $error("fast stop moved alone");
	property p_bit7;
		s_acc(i_rd, rng_pkg::ADDR_CONTROL) |=> !o_rdata[7];
	endproperty
	a_bit7: assert property (p_bit7) else $error("control bit7 set");
	property p_high;
		s_acc(i_wr, rng_pkg::ADDR_WORD_HIGH) ##1 s_acc(i_rd && !i_wr, rng_pkg::ADDR_WORD_HIGH)
			|=> o_rdata == $past(i_wdata, 2);
	endproperty
	a_high: assert property (p_high) else $error("high byte readback");
	property p_low;
		s_acc(i_wr, rng_pkg::ADDR_WORD_LOW) ##1 s_acc(i_rd && !i_wr, rng_pkg::ADDR_WORD_LOW)
			|=> o_rdata == $past(i_wdata, 2);
	endproperty
	a_low: assert property (p_low) else $error("low byte readback");
endmodule // rng_properties
